// file: core/hss_pkg.sv
/*
 * Shared constants for the high-side switch control register bank:
 * register addresses, field positions, reset and restart values,
 * source and pin mode codes, and PWM timing figures.
 * Assumes a 50 MHz core clock and a 7-bit register address space.
 */
package hss_pkg;
    // Register addresses on the 7-bit register port
    localparam logic [6:0] HSS_ADDR_SD = 7'h10;    // Switch shutdown control
    localparam logic [6:0] HSS_ADDR_HS1 = 7'h14;   // High-side control one
    localparam logic [6:0] HSS_ADDR_HS2 = 7'h15;   // High-side control two
    localparam logic [6:0] HSS_ADDR_GPIO = 7'h17;  // General pin config
    localparam logic [6:0] HSS_ADDR_DUTY = 7'h18;  // Channel A duty
    // Shutdown control bit positions
    localparam int HSS_OV_DIS_POS = 6;
    localparam int HSS_UV_DIS_POS = 5;
    localparam int HSS_REC_POS = 4;
    // Source field positions inside each control register
    localparam int HSS_SRC_LO_POS = 0;
    localparam int HSS_SRC_HI_POS = 4;
    // General pin config field positions
    localparam int HSS_FOD_POS = 6;
    localparam int HSS_PINB_POS = 3;
    localparam int HSS_PINA_POS = 0;
    // Reset values
    localparam logic [7:0] HSS_RST_VAL = 8'h00;
    localparam logic [2:0] HSS_SD_RST = 3'h0;
    localparam logic [11:0] HSS_SRC_RST = 12'h000;
    // Switch source codes
    localparam logic [2:0] HSS_SRC_OFF = 3'h0;
    localparam logic [2:0] HSS_SRC_ON = 3'h1;
    localparam logic [2:0] HSS_SRC_TMR_A = 3'h2;
    localparam logic [2:0] HSS_SRC_TMR_B = 3'h3;
    localparam logic [2:0] HSS_SRC_PWM_A = 3'h4;
    localparam logic [2:0] HSS_SRC_PWM_B = 3'h5;
    // Timer on-time codes that stop the timer
    localparam logic [2:0] HSS_TMR_STOP_LOW = 3'h0;
    localparam logic [2:0] HSS_TMR_STOP_HIGH = 3'h6;
    localparam logic [2:0] HSS_TMR_RSVD = 3'h7;
    // General pin mode codes (0..3 select the fail output)
    localparam logic [2:0] HSS_PIN_OFF = 3'h4;
    localparam logic [2:0] HSS_PIN_WAKE = 3'h5;
    localparam logic [2:0] HSS_PIN_LS_ON = 3'h6;
    localparam logic [2:0] HSS_PIN_HS_ON = 3'h7;
    // PWM timing
    localparam int HSS_CLK_HZ = 50_000_000;
    localparam int HSS_PWM_SLOW_HZ = 200;
    localparam int HSS_PWM_FAST_HZ = 400;
    localparam int HSS_PWM_SLOW_CYC = HSS_CLK_HZ / HSS_PWM_SLOW_HZ;
    localparam int HSS_PWM_FAST_CYC = HSS_CLK_HZ / HSS_PWM_FAST_HZ;
    localparam logic [7:0] HSS_DUTY_STEPS = 8'hff;
    localparam logic [7:0] HSS_STEP_LAST = 8'hfe;
    // Fault input synchroniser width: ov, uv, overcurrent x4, overtemp x4
    localparam int HSS_FLT_W = 10;
endpackage

// file: core/hss_ctrl.sv
/*
 * High-side switch control register bank with source selection,
 * supply fault shutdown and recovery, per-switch fault clearing,
 * general pin mode decode and the channel A pulse generator.
 * Assumes a deserialised register port, timer and channel B levels
 * from same-clock logic, and asynchronous analog fault flags.
 */
// Notes on behaviour
// - Reserved shutdown bits read zero, ignore writes
// - Bit 6 set suppresses overvoltage shutdown
// - Bit 5 set suppresses undervoltage shutdown
// - Bit 4 restores switches after supply fault
// - Shutdown reg clears; restart keeps bits 6..4
// - Source codes: off, on, timers, pulse channels
// - Switch fields at bits 2:0 and 6:4
// - Overcurrent or overtemperature clears switch field
// - Bits 7:6 pick fail output duty
// - Pin B field bits 5:3 picks mode
// - Pin config and duty survive restart
// - Duty zero off, 255 on, else fraction
// - Switch controls clear on every reset kind
// - Timer code 000 low, 110 high, stopped
// - Frequency select: 200Hz or 400Hz period
// - Assigned timer starts on running on-time code
`timescale 1ns/1ps
module hss_ctrl
    import hss_pkg::*;
#(
    parameter int PWM_SLOW_CYC = HSS_PWM_SLOW_CYC,
    parameter int PWM_FAST_CYC = HSS_PWM_FAST_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic soft_reset,
    input wire logic restart_entry,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [6:0] cmd_addr,
    input wire logic [7:0] cmd_wdata,
    output logic rsp_valid,
    output logic [7:0] rsp_rdata,
    input wire logic supply_ov,
    input wire logic supply_uv,
    input wire logic [3:0] sw_overcurrent,
    input wire logic [3:0] sw_overtemp,
    input wire logic [2:0] timer_a_on_code,
    input wire logic [2:0] timer_b_on_code,
    input wire logic cyclic_timer_a,
    input wire logic cyclic_timer_b,
    input wire logic pulse_channel_b,
    input wire logic pulse_a_fast,
    output logic [3:0] switch_on,
    output logic [1:0] timer_run,
    output logic pulse_channel_a,
    output logic [1:0] fail_output_duty,
    output logic [2:0] general_pin_a_mode,
    output logic [2:0] general_pin_b_mode,
    output logic [1:0] pin_fail_sel,
    output logic [1:0] pin_wake_en,
    output logic [1:0] pin_ls_on,
    output logic [1:0] pin_hs_on,
    output logic switch_shutdown
);
    // Cycles per duty step; truncation trims the period by under 255 cycles
    localparam logic [17:0] STEP_SLOW = 18'(PWM_SLOW_CYC / int'(HSS_DUTY_STEPS));
    localparam logic [17:0] STEP_FAST = 18'(PWM_FAST_CYC / int'(HSS_DUTY_STEPS));

    typedef struct packed {
        logic [2:0] sd_reg;          // {ov disable, uv disable, recovery}
        logic [11:0] src_reg;        // Four 3-bit source fields, switch one low
        logic [7:0] gpio_reg;        // Fail duty, pin B, pin A
        logic [7:0] duty_reg;        // Channel A duty value
        logic [7:0] rdata_reg;       // Read answer
        logic rvalid_reg;            // Read answer strobe
        logic [HSS_FLT_W-1:0] s1_reg; // Synchroniser stage one
        logic [HSS_FLT_W-1:0] s2_reg; // Synchroniser stage two
        logic [HSS_FLT_W-1:0] s3_reg; // Synchroniser stage three
        logic [HSS_FLT_W-1:0] flt_reg; // Accepted fault levels
        logic shut_reg;              // Supply shutdown in force
        logic [17:0] tick_reg;       // Cycles within a duty step
        logic [7:0] step_reg;        // Duty step within the period
        logic pwm_a_reg;             // Channel A level
        logic [3:0] sw_reg;          // Switch drive
    } hss_state_t;

    hss_state_t st_reg;
    hss_state_t st_next;
    logic shut_now;
    logic [1:0] tmr_lvl;

    // Timer level as seen by a switch; stopped codes force a fixed level
    function automatic logic tmr_level(input logic [2:0] code, input logic lvl);
        if (code == HSS_TMR_STOP_LOW || code == HSS_TMR_RSVD) begin
            return 1'b0;
        end else if (code == HSS_TMR_STOP_HIGH) begin
            return 1'b1;
        end
        return lvl;
    endfunction

    // Drive level selected by a source code
    function automatic logic src_level(input logic [2:0] code, input logic ta,
                                       input logic tb, input logic pa, input logic pb);
        case (code)
            HSS_SRC_ON: return 1'b1;
            HSS_SRC_TMR_A: return ta;
            HSS_SRC_TMR_B: return tb;
            HSS_SRC_PWM_A: return pa;
            HSS_SRC_PWM_B: return pb;
            default: return 1'b0; // Off and reserved codes
        endcase
    endfunction

    // True if any switch field holds the given code
    function automatic logic src_uses(input logic [11:0] src, input logic [2:0] code);
        return (src[2:0] == code) || (src[5:3] == code) ||
               (src[8:6] == code) || (src[11:9] == code);
    endfunction

    // Pin mode decode into one-hot actions
    function automatic logic [3:0] pin_decode(input logic [2:0] m);
        // Returns {hs on, ls on, wake, fail}; pin off gives all zero
        return {m == HSS_PIN_HS_ON, m == HSS_PIN_LS_ON, m == HSS_PIN_WAKE, ~m[2]};
    endfunction

    assign tmr_lvl = {tmr_level(timer_b_on_code, cyclic_timer_b),
                      tmr_level(timer_a_on_code, cyclic_timer_a)};
    // Supply shutdown from accepted fault levels and disable bits
    assign shut_now = (st_reg.flt_reg[0] & ~st_reg.sd_reg[2]) |
                      (st_reg.flt_reg[1] & ~st_reg.sd_reg[1]);

    // Next-state logic for the whole block
    always_comb begin
        logic [17:0] step_len;
        logic [HSS_FLT_W-1:0] agree;
        step_len = pulse_a_fast ? STEP_FAST : STEP_SLOW;
        st_next = st_reg;
        st_next.rvalid_reg = 1'b0;
        // Fault synchroniser; a change is accepted once stages two and three agree
        st_next.s1_reg = {sw_overtemp, sw_overcurrent, supply_uv, supply_ov};
        st_next.s2_reg = st_reg.s1_reg;
        st_next.s3_reg = st_reg.s2_reg;
        agree = ~(st_reg.s2_reg ^ st_reg.s3_reg);
        st_next.flt_reg = (agree & st_reg.s3_reg) | (~agree & st_reg.flt_reg);
        // Register writes; reserved positions are dropped
        if (cmd_valid && cmd_write) begin
            if (cmd_addr == HSS_ADDR_SD) begin
                st_next.sd_reg = cmd_wdata[HSS_OV_DIS_POS:HSS_REC_POS];
            end else if (cmd_addr == HSS_ADDR_HS1) begin
                st_next.src_reg[2:0] = cmd_wdata[HSS_SRC_LO_POS +: 3];
                st_next.src_reg[5:3] = cmd_wdata[HSS_SRC_HI_POS +: 3];
            end else if (cmd_addr == HSS_ADDR_HS2) begin
                st_next.src_reg[8:6] = cmd_wdata[HSS_SRC_LO_POS +: 3];
                st_next.src_reg[11:9] = cmd_wdata[HSS_SRC_HI_POS +: 3];
            end else if (cmd_addr == HSS_ADDR_GPIO) begin
                st_next.gpio_reg = cmd_wdata;
            end else if (cmd_addr == HSS_ADDR_DUTY) begin
                st_next.duty_reg = cmd_wdata;
            end
        end
        // Register reads; unmapped addresses answer zero
        if (cmd_valid && !cmd_write) begin
            st_next.rvalid_reg = 1'b1;
            if (cmd_addr == HSS_ADDR_SD) begin
                st_next.rdata_reg = {1'b0, st_reg.sd_reg, 4'h0};
            end else if (cmd_addr == HSS_ADDR_HS1) begin
                st_next.rdata_reg = {1'b0, st_reg.src_reg[5:3], 1'b0, st_reg.src_reg[2:0]};
            end else if (cmd_addr == HSS_ADDR_HS2) begin
                st_next.rdata_reg = {1'b0, st_reg.src_reg[11:9], 1'b0, st_reg.src_reg[8:6]};
            end else if (cmd_addr == HSS_ADDR_GPIO) begin
                st_next.rdata_reg = st_reg.gpio_reg;
            end else if (cmd_addr == HSS_ADDR_DUTY) begin
                st_next.rdata_reg = st_reg.duty_reg;
            end else begin
                st_next.rdata_reg = HSS_RST_VAL;
            end
        end
        // Supply shutdown; without recovery the fields are wiped on entry
        st_next.shut_reg = shut_now;
        if (shut_now && !st_reg.shut_reg && !st_reg.sd_reg[0]) begin
            st_next.src_reg = HSS_SRC_RST;
        end
        // Switch faults win over a write in the same cycle
        for (int i = 0; i < 4; i++) begin
            if (st_reg.flt_reg[2 + i] || st_reg.flt_reg[6 + i]) begin
                st_next.src_reg[3*i +: 3] = HSS_SRC_OFF;
            end
        end
        // Channel A: 255 steps per period, high while step below duty
        if (st_reg.tick_reg + 18'h1 >= step_len) begin
            st_next.tick_reg = 18'h0;
            st_next.step_reg = (st_reg.step_reg == HSS_STEP_LAST) ? 8'h00
                               : st_reg.step_reg + 8'h01;
        end else begin
            st_next.tick_reg = st_reg.tick_reg + 18'h1;
        end
        st_next.pwm_a_reg = (st_reg.step_reg < st_reg.duty_reg);
        // Switch drive, forced off during supply shutdown
        for (int i = 0; i < 4; i++) begin
            st_next.sw_reg[i] = ~st_reg.shut_reg &
                src_level(st_reg.src_reg[3*i +: 3], tmr_lvl[0], tmr_lvl[1],
                          st_reg.pwm_a_reg, pulse_channel_b);
        end
        // Soft reset clears all configuration; restart keeps selected bits
        if (soft_reset) begin
            st_next.sd_reg = HSS_SD_RST;
            st_next.src_reg = HSS_SRC_RST;
            st_next.gpio_reg = HSS_RST_VAL;
            st_next.duty_reg = HSS_RST_VAL;
            st_next.sw_reg = 4'h0;
        end else if (restart_entry) begin
            st_next.src_reg = HSS_SRC_RST;
            st_next.sw_reg = 4'h0;
        end
    end

    // State register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs
    assign rsp_valid = st_reg.rvalid_reg;
    assign rsp_rdata = st_reg.rdata_reg;
    assign switch_on = st_reg.sw_reg;
    assign pulse_channel_a = st_reg.pwm_a_reg;
    assign switch_shutdown = st_reg.shut_reg;
    assign fail_output_duty = st_reg.gpio_reg[HSS_FOD_POS +: 2];
    assign general_pin_a_mode = st_reg.gpio_reg[HSS_PINA_POS +: 3];
    assign general_pin_b_mode = st_reg.gpio_reg[HSS_PINB_POS +: 3];
    assign {pin_hs_on[0], pin_ls_on[0], pin_wake_en[0], pin_fail_sel[0]} =
        pin_decode(general_pin_a_mode);
    assign {pin_hs_on[1], pin_ls_on[1], pin_wake_en[1], pin_fail_sel[1]} =
        pin_decode(general_pin_b_mode);
    // A timer runs only when assigned and given a running on-time code
    assign timer_run[0] = src_uses(st_reg.src_reg, HSS_SRC_TMR_A) &&
        timer_a_on_code != HSS_TMR_STOP_LOW && timer_a_on_code < HSS_TMR_STOP_HIGH;
    assign timer_run[1] = src_uses(st_reg.src_reg, HSS_SRC_TMR_B) &&
        timer_b_on_code != HSS_TMR_STOP_LOW && timer_b_on_code < HSS_TMR_STOP_HIGH;

    // Read of shutdown control one cycle earlier
    sequence s_sd_read;
        cmd_valid && !cmd_write && cmd_addr == HSS_ADDR_SD;
    endsequence
    property p_rsvd_zero;
        @(posedge core_clk) disable iff (rst)
        s_sd_read |=> rsp_valid && rsp_rdata[7] == 1'b0 && rsp_rdata[3:0] == 4'h0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits read nonzero");

    property p_ov_shut;
        @(posedge core_clk) disable iff (rst)
        (st_reg.flt_reg[0] && !st_reg.sd_reg[2]) |=> ##1 switch_on == 4'h0;
    endproperty
    a_ov_shut: assert property (p_ov_shut) else $error("switch on during overvoltage");

    property p_uv_shut;
        @(posedge core_clk) disable iff (rst)
        (st_reg.flt_reg[1] && !st_reg.sd_reg[1]) |=> ##1 switch_on == 4'h0;
    endproperty
    a_uv_shut: assert property (p_uv_shut) else $error("switch on during undervoltage");

    property p_no_recover;
        @(posedge core_clk) disable iff (rst)
        ($rose(st_reg.shut_reg) && !$past(st_reg.sd_reg[0])) |-> st_reg.src_reg == 12'h000;
    endproperty
    a_no_recover: assert property (p_no_recover)
        else $error("fields kept without recovery");

    property p_restart_sd;
        @(posedge core_clk) disable iff (rst)
        (restart_entry && !soft_reset && !cmd_valid) |=> st_reg.sd_reg == $past(st_reg.sd_reg);
    endproperty
    a_restart_sd: assert property (p_restart_sd)
        else $error("restart altered shutdown bits");

    property p_restart_keep;
        @(posedge core_clk) disable iff (rst)
        (restart_entry && !soft_reset && !cmd_valid) |=>
            st_reg.gpio_reg == $past(st_reg.gpio_reg) && st_reg.duty_reg == $past(st_reg.duty_reg);
    endproperty
    a_restart_keep: assert property (p_restart_keep)
        else $error("restart altered config");

    sequence s_any_reset;
        soft_reset || restart_entry;
    endsequence
    property p_reset_off;
        @(posedge core_clk) disable iff (rst)
        s_any_reset |=> st_reg.src_reg == 12'h000 ##1 switch_on == 4'h0;
    endproperty
    a_reset_off: assert property (p_reset_off)
        else $error("switch not off after reset");

    // Fields of switches with an accepted overcurrent or overtemperature
    logic [11:0] flt_mask;
    assign flt_mask = {{3{st_reg.flt_reg[5] | st_reg.flt_reg[9]}},
                       {3{st_reg.flt_reg[4] | st_reg.flt_reg[8]}},
                       {3{st_reg.flt_reg[3] | st_reg.flt_reg[7]}},
                       {3{st_reg.flt_reg[2] | st_reg.flt_reg[6]}}};
    property p_fault_clear;
        @(posedge core_clk) disable iff (rst)
        (flt_mask != 12'h000) |=> (st_reg.src_reg & $past(flt_mask)) == 12'h000;
    endproperty
    a_fault_clear: assert property (p_fault_clear)
        else $error("faulted field not cleared");

    property p_duty_full;
        @(posedge core_clk) disable iff (rst)
        (st_reg.duty_reg == 8'hff) [*2] |-> pulse_channel_a;
    endproperty
    a_duty_full: assert property (p_duty_full) else $error("full duty output low");

    property p_duty_zero;
        @(posedge core_clk) disable iff (rst)
        (st_reg.duty_reg == 8'h00) [*2] |-> !pulse_channel_a;
    endproperty
    a_duty_zero: assert property (p_duty_zero) else $error("zero duty output high");
endmodule // hss_ctrl

// file: verif/hss_host.sv
/*
 * Host model for the switch control bank: issues register writes and
 * reads on the command port, one command at a time.
 * Assumes the bank registers its read answer on the same edge that takes the command.
 */
`timescale 1ns/1ps
module hss_host (
    input wire logic core_clk,
    output logic cmd_valid,
    output logic cmd_write,
    output logic [6:0] cmd_addr,
    output logic [7:0] cmd_wdata,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_rdata
);
    // Idle port at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_addr = 7'h00;
        cmd_wdata = 8'h00;
    end

    // Write: held up to the taking edge, then released with scrambled data
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1;
        cmd_valid = 1'b1;
        cmd_write = 1'b1;
        cmd_addr = a;
        cmd_wdata = d;
        @(posedge core_clk);
        #1;
        cmd_valid = 1'b0;
        cmd_wdata = ~d;
    endtask

    // Read: the registered answer stands for one cycle after the taking edge,
    // so it is picked up just after that edge, before the next one clears it
    task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic ok);
        @(posedge core_clk);
        #1;
        cmd_valid = 1'b1;
        cmd_write = 1'b0;
        cmd_addr = a;
        @(posedge core_clk);
        #1;
        cmd_valid = 1'b0;
        cmd_addr = ~a;
        d = rsp_rdata;
        ok = rsp_valid;
    endtask
endmodule // hss_host

// file: verif/tb_top.sv
/*
 * Self-checking bench for the switch control bank: register table,
 * source selection, supply and switch faults, pin decode, channel A.
 * Assumes the host model drives the command port; PWM periods shortened.
 */
`timescale 1ns/1ps
module tb_top
    import hss_pkg::*;
;
    localparam int SLOW = 2550;
    localparam int FAST = 1275;
    localparam int LIMIT = 60000;
    typedef struct packed {logic [6:0] a; logic [7:0] d; logic [7:0] e;} hss_row_t;
    // Write data beside the value that must read back
    localparam hss_row_t ROWS [6] = '{
        '{7'h10, 8'hff, 8'h70}, '{7'h14, 8'hff, 8'h77}, '{7'h15, 8'h5d, 8'h55},
        '{7'h17, 8'ha5, 8'ha5}, '{7'h18, 8'h80, 8'h80}, '{7'h11, 8'hff, 8'h00}};
    logic core_clk = 1'b0, rst = 1'b1, soft_reset = 1'b0, restart_entry = 1'b0;
    logic cmd_valid, cmd_write, rsp_valid, ok;
    logic [6:0] cmd_addr;
    logic [7:0] cmd_wdata, rsp_rdata, rv;
    logic supply_ov = 1'b0, supply_uv = 1'b0, pulse_a_fast = 1'b0;
    logic [3:0] sw_overcurrent = 4'h0, sw_overtemp = 4'h0, switch_on;
    logic [2:0] timer_a_on_code = 3'h0, timer_b_on_code = 3'h0;
    logic cyclic_timer_a = 1'b0, cyclic_timer_b = 1'b0, pulse_channel_b = 1'b0;
    logic [1:0] timer_run, fail_output_duty, pin_fail_sel, pin_wake_en, pin_ls_on, pin_hs_on;
    logic pulse_channel_a, switch_shutdown;
    logic [2:0] general_pin_a_mode, general_pin_b_mode;
    int num_errors = 0, checks_done = 0, cycles = 0, highs;

    hss_ctrl #(.PWM_SLOW_CYC(SLOW), .PWM_FAST_CYC(FAST)) DUT (.core_clk(core_clk),
        .rst(rst), .soft_reset(soft_reset), .restart_entry(restart_entry),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .supply_ov(supply_ov), .supply_uv(supply_uv), .sw_overcurrent(sw_overcurrent),
        .sw_overtemp(sw_overtemp), .timer_a_on_code(timer_a_on_code),
        .timer_b_on_code(timer_b_on_code), .cyclic_timer_a(cyclic_timer_a),
        .cyclic_timer_b(cyclic_timer_b), .pulse_channel_b(pulse_channel_b),
        .pulse_a_fast(pulse_a_fast), .switch_on(switch_on), .timer_run(timer_run),
        .pulse_channel_a(pulse_channel_a), .fail_output_duty(fail_output_duty),
        .general_pin_a_mode(general_pin_a_mode), .general_pin_b_mode(general_pin_b_mode),
        .pin_fail_sel(pin_fail_sel), .pin_wake_en(pin_wake_en), .pin_ls_on(pin_ls_on),
        .pin_hs_on(pin_hs_on), .switch_shutdown(switch_shutdown));
    hss_host host (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata));

    // 50 MHz clock
    always #10 core_clk = ~core_clk;

    // Hang guard: a stuck run is a failure, not a silent stop
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            num_errors++;
            conclude();
        end
    end

    task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask

    // Read back through the host and compare, also checking the answer flag
    task automatic rchk(input logic [6:0] a, input logic [7:0] e);
        host.rd(a, rv, ok);
        check("rsp_valid", {7'h00, ok}, 8'h01);
        check("rdata", rv, e);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // Count channel A high cycles over one full period
    task automatic count_high(input int per);
        highs = 0;
        repeat (per) begin
            @(posedge core_clk);
            #1;
            highs += int'(pulse_channel_a);
        end
    endtask

    function automatic logic exp_sw(input logic [2:0] c, input logic [3:0] v);
        case (c)
            HSS_SRC_ON: exp_sw = 1'b1;
            HSS_SRC_TMR_A: exp_sw = v[0];
            HSS_SRC_TMR_B: exp_sw = v[1];
            HSS_SRC_PWM_A: exp_sw = v[2];
            HSS_SRC_PWM_B: exp_sw = v[3];
            default: exp_sw = 1'b0; // Off and reserved codes keep the switch dark
        endcase
    endfunction

    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge core_clk);
        #1;
        rst = 1'b0;
        check("idle", {switch_on, 2'b00, switch_shutdown, rsp_valid}, 8'h00);
        // Register table rows: reserved bits and unmapped address read zero
        foreach (ROWS[i]) begin
            host.wr(ROWS[i].a, ROWS[i].d);
            rchk(ROWS[i].a, ROWS[i].e);
        end
        // Duty full on so channel A is a steady high source; small duties avoided
        host.wr(HSS_ADDR_DUTY, 8'hff);
        host.wr(HSS_ADDR_SD, 8'h00);
        // Running on-time codes so the timer levels pass through to the switches
        {timer_a_on_code, timer_b_on_code} = 6'o11;
        for (int c = 0; c < 8; c++) begin
            for (int p = 0; p < 2; p++) begin
                {cyclic_timer_b, cyclic_timer_a, pulse_channel_b} = p ? 3'b010 : 3'b101;
                host.wr(HSS_ADDR_HS1, {1'b0, 3'(c), 1'b0, 3'(c)});
                host.wr(HSS_ADDR_HS2, {1'b0, 3'(c), 1'b0, 3'(c)});
                wait_cyc(2);
                check("switch_on", {4'h0, switch_on},
                    {4'h0, {4{exp_sw(3'(c),
                    {pulse_channel_b, 1'b1, cyclic_timer_b, cyclic_timer_a})}}});
            end
        end
        // Timer run decode; switch one on timer A and switch two on timer B keep both timers assigned here
        host.wr(HSS_ADDR_HS1, 8'h32);
        for (int c = 0; c < 8; c++) begin
            {timer_a_on_code, timer_b_on_code} = {3'(c), 3'(c)};
            wait_cyc(1);
            check("timer_run", {6'h00, timer_run},
                (c == 0 || c == 6 || c == 7) ? 8'h00 : 8'h03);
            // Timer A level is high and timer B level low here; stop codes force levels
            check("timer_level", {6'h00, switch_on[1:0]},
                {6'h00, c == 6, c != 0 && c != 7});
        end
        // Unassigned timers do not run; checked only with on-time code 7 on both timers
        host.wr(HSS_ADDR_HS1, 8'h00);
        wait_cyc(1);
        check("timer_run_unassigned", {6'h00, timer_run}, 8'h00);
        // Pin modes for both general pins, fail duty field
        for (int m = 0; m < 8; m++) begin
            host.wr(HSS_ADDR_GPIO, {2'b10, 3'(m), 3'(m)});
            wait_cyc(1);
            check("modes", {fail_output_duty, general_pin_b_mode, general_pin_a_mode},
                {2'b10, 3'(m), 3'(m)});
            check("pins", {pin_fail_sel, pin_wake_en, pin_ls_on, pin_hs_on},
                {{2{m < 4}}, {2{m == 5}}, {2{m == 6}}, {2{m == 7}}});
        end
        // Channel A duty: off, full on, half at both periods
        host.wr(HSS_ADDR_DUTY, 8'h00);
        count_high(SLOW);
        check("duty_zero", 8'(highs), 8'h00);
        host.wr(HSS_ADDR_DUTY, 8'h80);
        count_high(SLOW);
        check("duty_half_slow", 8'(highs / 10), 8'd128);
        pulse_a_fast = 1'b1;
        count_high(FAST);
        check("duty_half_fast", 8'(highs / 5), 8'd128);
        host.wr(HSS_ADDR_DUTY, 8'hff);
        count_high(FAST);
        check("duty_full", 8'(highs / 5), 8'd255);
        // Overvoltage shutdown without recovery clears the fields
        host.wr(HSS_ADDR_HS1, 8'h11);
        supply_ov = 1'b1;
        wait_cyc(8);
        check("ov_off", {3'h0, switch_shutdown, switch_on}, 8'h10);
        rchk(HSS_ADDR_HS1, 8'h00);
        supply_ov = 1'b0;
        wait_cyc(8);
        check("no_recover", {4'h0, switch_on}, 8'h00);
        // Undervoltage with recovery restores the earlier state
        host.wr(HSS_ADDR_SD, 8'h10);
        host.wr(HSS_ADDR_HS1, 8'h11);
        supply_uv = 1'b1;
        wait_cyc(8);
        check("uv_off", {4'h0, switch_on}, 8'h00);
        rchk(HSS_ADDR_HS1, 8'h11);
        supply_uv = 1'b0;
        wait_cyc(8);
        check("recovered", {4'h0, switch_on}, 8'h03);
        // Both shutdowns suppressed
        host.wr(HSS_ADDR_SD, 8'h60);
        {supply_ov, supply_uv} = 2'b11;
        wait_cyc(8);
        check("suppressed", {3'h0, switch_shutdown, switch_on}, 8'h03);
        {supply_ov, supply_uv} = 2'b00;
        // Switch faults clear only their own field
        host.wr(HSS_ADDR_HS2, 8'h11);
        sw_overcurrent = 4'h4;
        wait_cyc(8);
        rchk(HSS_ADDR_HS2, 8'h10);
        sw_overtemp = 4'h8;
        wait_cyc(8);
        rchk(HSS_ADDR_HS2, 8'h00);
        {sw_overcurrent, sw_overtemp} = 8'h00;
        // Restart keeps shutdown bits 6..4, pin config and duty
        host.wr(HSS_ADDR_SD, 8'h70);
        host.wr(HSS_ADDR_GPIO, 8'ha5);
        host.wr(HSS_ADDR_HS1, 8'h11);
        restart_entry = 1'b1;
        wait_cyc(1);
        restart_entry = 1'b0;
        rchk(HSS_ADDR_SD, 8'h70);
        rchk(HSS_ADDR_HS1, 8'h00);
        rchk(HSS_ADDR_GPIO, 8'ha5);
        rchk(HSS_ADDR_DUTY, 8'hff);
        // Soft reset clears all five registers
        soft_reset = 1'b1;
        wait_cyc(1);
        soft_reset = 1'b0;
        for (int i = 0; i < 5; i++)
            rchk(ROWS[i].a, 8'h00);
        conclude();
    end
endmodule // tb_top
